// ---- design/pbedc_pkg.sv ----
// Purpose: Shared constants and types for the port B change detector
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Register offsets are byte addresses
package pbedc_pkg;
  localparam int unsigned PBEDC_AW = 4;
  localparam logic [3:0] PBEDC_OFS_RISE = 4'h0;
  localparam logic [3:0] PBEDC_OFS_FALL = 4'h4;
  localparam logic [3:0] PBEDC_OFS_FLAG = 4'h8;
  localparam logic [3:0] PBEDC_OFS_CTRL = 4'hc;
  localparam logic [7:0] PBEDC_RST_REG = 8'h00;
  localparam logic [7:0] PBEDC_IMPL_MASK = 8'hf0;
  localparam int unsigned PBEDC_CTRL_MEN_BIT = 0;
  localparam int unsigned PBEDC_CTRL_SUM_BIT = 1;
  localparam int unsigned PBEDC_SYNC_STAGES = 2;
  // Register write request decoded from the bus
  typedef struct packed {
    logic rise;
    logic fall;
    logic flag;
    logic ctrl;
  } pbedc_wsel_t;
endpackage

// ---- design/pbedc_top.sv ----
// Purpose: Edge detector with sticky flags for port B pins 7 to 4
// Assumes: Pins are asynchronous to pclk; standard APB master
// Notes: Port A flags arrive as a ready OR term from outside
//
// Contract
// [RULE1] Rise enable watches pin for rising edges
// [RULE2] Fall enable watches pin for falling edges
// [RULE3] Cleared enable ignores that edge polarity
// [RULE4] Enabled matching edge sets pin flag
// [RULE5] Enabled edge raises flag and summary
// [RULE6] Flag stays set until software writes zero
// [RULE7] Bits 3 to 0 read zero, ignore writes
// [RULE8] All enables and flags reset to zero
// [RULE9] Detection always; interrupt only when master enabled
// [RULE10] Summary flag ORs all flags both ports
// [RULE11] Edge during flag write keeps flag set
// [RULE12] Edge in sleep sets flag and wakes; here wake_request follows change_irq, so it needs master enable
// [RULE13] Synchronise pins, compare successive samples
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`default_nettype none
module pbedc_top
  import pbedc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PBEDC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] port_b_pins,
  input wire logic port_a_any_flag,
  output logic change_irq_summary_flag,
  output logic change_irq,
  output logic wake_request
);
  logic [7:0] sync1_ff, sync2_ff, prev_ff;
  logic [7:0] rise_enable_b_ff, fall_enable_b_ff, edge_flag_b_ff;
  logic change_irq_master_enable_ff;
  logic [7:0] nxt_rise, nxt_fall, nxt_flag;
  logic nxt_men;
  logic [31:0] prdata_ff, nxt_prdata;
  logic [7:0] rise_evt, fall_evt, edge_evt;
  pbedc_wsel_t wsel;
  wire logic access = psel & penable;
  wire logic wr_ok = access & pwrite & pstrb[0];
  wire logic known = (paddr == PBEDC_OFS_RISE) | (paddr == PBEDC_OFS_FALL) |
                     (paddr == PBEDC_OFS_FLAG) | (paddr == PBEDC_OFS_CTRL);

  // Two-stage synchroniser, then previous sample for edge compare
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= PBEDC_RST_REG;
      sync2_ff <= PBEDC_RST_REG;
      prev_ff <= PBEDC_RST_REG;
    end else begin
      sync1_ff <= port_b_pins; // see [RULE13]
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  // Edge events gated per pin by enable; low nibble never fires
  assign rise_evt = sync2_ff & ~prev_ff & rise_enable_b_ff; // see [RULE1]
  assign fall_evt = ~sync2_ff & prev_ff & fall_enable_b_ff; // see [RULE2]
  assign edge_evt = (rise_evt | fall_evt) & PBEDC_IMPL_MASK; // see [RULE3]

  // Write decode
  assign wsel.rise = wr_ok & (paddr == PBEDC_OFS_RISE);
  assign wsel.fall = wr_ok & (paddr == PBEDC_OFS_FALL);
  assign wsel.flag = wr_ok & (paddr == PBEDC_OFS_FLAG);
  assign wsel.ctrl = wr_ok & (paddr == PBEDC_OFS_CTRL);

  // Next values; unimplemented bits masked out of every write
  assign nxt_rise = wsel.rise ? (pwdata[7:0] & PBEDC_IMPL_MASK)
                              : rise_enable_b_ff; // see [RULE7]
  assign nxt_fall = wsel.fall ? (pwdata[7:0] & PBEDC_IMPL_MASK)
                              : fall_enable_b_ff; // see [RULE7]
  // Hardware set wins over a software write of zero
  assign nxt_flag = (wsel.flag ? (pwdata[7:0] & PBEDC_IMPL_MASK)
                               : edge_flag_b_ff)
                    | edge_evt; // see [RULE4] see [RULE6] see [RULE11]
  assign nxt_men = wsel.ctrl ? pwdata[PBEDC_CTRL_MEN_BIT]
                             : change_irq_master_enable_ff;

  // Register file
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rise_enable_b_ff <= PBEDC_RST_REG; // see [RULE8]
      fall_enable_b_ff <= PBEDC_RST_REG;
      edge_flag_b_ff <= PBEDC_RST_REG;
      change_irq_master_enable_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      rise_enable_b_ff <= nxt_rise;
      fall_enable_b_ff <= nxt_fall;
      edge_flag_b_ff <= nxt_flag;
      change_irq_master_enable_ff <= nxt_men;
      prdata_ff <= nxt_prdata;
    end
  end

  // Read mux, captured in setup phase so data is a flop in access
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (psel & ~penable & ~pwrite) begin
      unique case (paddr)
        PBEDC_OFS_RISE: nxt_prdata[7:0] = rise_enable_b_ff;
        PBEDC_OFS_FALL: nxt_prdata[7:0] = fall_enable_b_ff;
        PBEDC_OFS_FLAG: nxt_prdata[7:0] = edge_flag_b_ff;
        PBEDC_OFS_CTRL: begin
          nxt_prdata[PBEDC_CTRL_MEN_BIT] = change_irq_master_enable_ff;
          nxt_prdata[PBEDC_CTRL_SUM_BIT] = change_irq_summary_flag;
        end
        default: nxt_prdata = 32'h0000_0000;
      endcase
    end else begin
      nxt_prdata = prdata_ff;
    end
  end

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = access & ~known;

  // Summary, interrupt and wake outputs
  assign change_irq_summary_flag = (|edge_flag_b_ff) | port_a_any_flag; // see [RULE10]
  assign change_irq = change_irq_summary_flag
                      & change_irq_master_enable_ff; // see [RULE9] see [RULE5]
  assign wake_request = change_irq; // see [RULE12]

  // Checks
  flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    |edge_evt |=> (edge_flag_b_ff & $past(edge_evt)) == $past(edge_evt))
    else $error("enabled edge did not set flag"); // see [RULE4]
  rise_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!rise_enable_b_ff[4] && !fall_enable_b_ff[4] && !edge_flag_b_ff[4]
     && !wsel.flag) |=> !edge_flag_b_ff[4])
    else $error("flag set without enable"); // see [RULE3]
  sticky_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (edge_flag_b_ff[7] && !wsel.flag) |=> edge_flag_b_ff[7])
    else $error("flag dropped without write"); // see [RULE6]
  low_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rise_enable_b_ff[3:0] | fall_enable_b_ff[3:0] | edge_flag_b_ff[3:0])
    == 4'h0)
    else $error("low bits not zero"); // see [RULE7]
  set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wsel.flag && edge_evt[5]) |=> edge_flag_b_ff[5])
    else $error("clear beat edge"); // see [RULE11]
  irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    change_irq == (change_irq_master_enable_ff && change_irq_summary_flag))
    else $error("irq gating wrong"); // see [RULE9]
  summary_or_a: assert property (@(posedge pclk) disable iff (!presetn)
    (|edge_flag_b_ff) |-> change_irq_summary_flag)
    else $error("summary missing flag"); // see [RULE10]
  rise_detect_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rise_enable_b_ff[6] && $rose(sync2_ff[6])) |=> edge_flag_b_ff[6])
    else $error("rising edge missed"); // see [RULE1]
  fall_detect_a: assert property (@(posedge pclk) disable iff (!presetn)
    (fall_enable_b_ff[6] && $fell(sync2_ff[6])) |=> edge_flag_b_ff[6])
    else $error("falling edge missed"); // see [RULE2]
  wake_a: assert property (@(posedge pclk) disable iff (!presetn)
    (change_irq_master_enable_ff && |edge_evt) |=> ##0 wake_request)
    else $error("no wake on edge"); // see [RULE12]
  cov_rise_c: cover property (@(posedge pclk) disable iff (!presetn)
    |rise_evt);
  cov_fall_c: cover property (@(posedge pclk) disable iff (!presetn)
    |fall_evt);
  cov_race_c: cover property (@(posedge pclk) disable iff (!presetn)
    wsel.flag && |edge_evt);
  cov_irq_c: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(change_irq));
endmodule
`default_nettype wire

// ---- verif/pbedc_pin_model.sv ----
// Purpose: Drives port B pins from a requested level
// Assumes: Requests change just after a clock edge
// Notes: Pins 3 to 0 toggle every cycle and must be ignored
`default_nettype none
module pbedc_pin_model (
  input wire logic pclk,
  input wire logic [3:0] level,
  output logic [7:0] pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] hi = 4'h0;
  logic [3:0] junk_ff = 4'h5;
  // Unused pins keep moving so a stray detector shows up
  always @(posedge pclk) junk_ff <= ~junk_ff;
  // Upper pins follow the request off the clock edge
  always @(level) hi <= #13 level;
  assign pins = {hi, junk_ff};
endmodule
`default_nettype wire

// ---- verif/pbedc_bench.sv ----
// Purpose: Register and pin scenarios for the port B change detector
// Assumes: Zero wait APB slave, flag set 3 edges after a pin change
// Notes: Pin 6 and 4 watch rising edges, pins 7 and 5 falling edges
`default_nettype none
module pbedc_bench import pbedc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [3:0] paddr = 4'h0, pstrb = 4'hf, level = 4'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, sum, irq, wake, er, port_a = 0;
  logic [7:0] pins;
  int fails = 0, tests_run = 0;
  always #50 pclk = ~pclk;
  pbedc_pin_model u_pbedc_pin_model (.pclk(pclk), .level(level),
    .pins(pins));
  pbedc_top u_pbedc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_b_pins(pins), .port_a_any_flag(port_a),
    .change_irq_summary_flag(sum), .change_irq(irq), .wake_request(wake));
  // One APB transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [3:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %0t got %h expected %h", $time, g, e);
      fails++;
    end
  endtask
  task automatic close_out();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog at 1000 cycles, far beyond the under 100 cycles the tests need
  initial begin
    #100000;
    fails++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 4'(i * 4), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b1, PBEDC_OFS_RISE, 32'h5f);
    apb(1'b1, PBEDC_OFS_FALL, 32'haf);
    pstrb <= 4'he;
    apb(1'b1, PBEDC_OFS_RISE, 32'hff);
    pstrb <= 4'hf;
    apb(1'b0, PBEDC_OFS_RISE, 32'h0);
    chk(rd, 32'h50);
    apb(1'b0, PBEDC_OFS_FALL, 32'h0);
    chk(rd, 32'ha0);
    // Rising edge on all upper pins, master enable still off
    level <= 4'hf;
    repeat (5) @(posedge pclk);
    #1;
    chk(sum, 1'b1);
    chk(irq, 1'b0);
    apb(1'b0, PBEDC_OFS_FLAG, 32'h0);
    chk(rd, 32'h50);
    level <= 4'h0;
    repeat (5) @(posedge pclk);
    apb(1'b0, PBEDC_OFS_FLAG, 32'h0);
    chk(rd, 32'hf0);
    apb(1'b1, PBEDC_OFS_CTRL, 32'h1);
    #1;
    chk({irq, wake}, 2'b11);
    apb(1'b0, PBEDC_OFS_CTRL, 32'h0);
    chk(rd, 32'h3);
    apb(1'b1, PBEDC_OFS_FLAG, 32'h70);
    apb(1'b0, PBEDC_OFS_FLAG, 32'h0);
    chk(rd, 32'h70);
    apb(1'b1, PBEDC_OFS_FLAG, 32'h0);
    #1;
    chk({sum, irq}, 2'b00);
    port_a <= 1'b1;
    @(posedge pclk);
    #1;
    chk({sum, irq}, 2'b11);
    apb(1'b0, 4'h1, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    close_out();
  end
endmodule
`default_nettype wire
